// File: hw/qhb_dummy_unused.sv
// Spare design file: holds no logic of its own.
// Assumes every host pin function sits in qhb_host_pins.

// File: hw/qhb_host_pins.sv
// Host-facing pin logic of a four-channel UART: split and combined strobe
// bus styles, shared interrupt, mode-dependent reset, call and RTS pins.
// Assumes all pins are asynchronous to clk and the core runs at 40 MHz.
`timescale 1ns/1ps

module qhb_host_pins (
	clk,
	reset,
	bus_style_pin,
	reset_pin,
	host_bus,
	incoming_call_input_n,
	rx_room,
	tx_serial,
	rx_pin,
	data_out,
	data_oe_n,
	irq_pin,
	chan_int_bcd,
	request_to_send_n,
	tx_pin,
	rx_serial
);
	import qhb_pkg::*;

	input  wire logic                                clk;
	input  wire logic                                reset;
	input  wire logic                                bus_style_pin;
	input  wire logic                                reset_pin;
	input  wire qhb_pkg::qhb_bus_t                   host_bus;
	input  wire logic [qhb_pkg::CHANNELS-1:0]        incoming_call_input_n;
	input  wire logic [qhb_pkg::CHANNELS-1:0]        rx_room;
	input  wire logic [qhb_pkg::CHANNELS-1:0]        tx_serial;
	input  wire logic [qhb_pkg::CHANNELS-1:0]        rx_pin;
	output logic      [qhb_pkg::DATA_W-1:0]          data_out;
	output logic                                     data_oe_n;
	output logic                                     irq_pin;
	output logic      [qhb_pkg::CHANNELS-1:1]        chan_int_bcd;
	output logic      [qhb_pkg::CHANNELS-1:0]        request_to_send_n;
	output logic      [qhb_pkg::CHANNELS-1:0]        tx_pin;
	output logic      [qhb_pkg::CHANNELS-1:0]        rx_serial;

	localparam int NREG = CHANNELS * REGS_PER_CH;
	localparam int SW   = $bits(qhb_bus_t) + CHANNELS * 2 + 2;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [SW-1:0]       sync1_q;
	logic [SW-1:0]       sync2_q;
	wire  [SW-1:0]       pins_w = {host_bus, incoming_call_input_n,
	                               rx_pin, bus_style_pin, reset_pin};

	// Two stages; only the second stage is read by logic
	always_ff @(posedge clk) begin
		if (reset) begin
			sync1_q <= {BUS_IDLE, {CHANNELS{1'b1}}, {CHANNELS{1'b1}}, 2'b10};
			sync2_q <= {BUS_IDLE, {CHANNELS{1'b1}}, {CHANNELS{1'b1}}, 2'b10};
		end else begin
			sync1_q <= pins_w;
			sync2_q <= sync1_q;
		end
	end

	qhb_bus_t              bus_s;
	wire [CHANNELS-1:0]    call_n_s  = sync2_q[2*CHANNELS+1 -: CHANNELS];
	wire [CHANNELS-1:0]    rx_s      = sync2_q[CHANNELS+1 -: CHANNELS];
	wire                   style_s   = sync2_q[1];
	wire                   rstpin_s  = sync2_q[0];
	assign bus_s = sync2_q[SW-1 -: $bits(qhb_bus_t)];

	// ------------------------------------------------------------
	// Mode and reset
	// ------------------------------------------------------------
	logic mode_split_q;
	// Pin polarity follows the latched bus style
	wire  pin_rst_w = mode_split_q ? rstpin_s : ~rstpin_s;
	wire  rst_any   = reset | pin_rst_w;
	// Style in force after this edge; reset outputs follow it so the
	// shared request does not pulse low while combined style latches
	wire  mode_next_w = reset     ? MODE_RESET :
	                    pin_rst_w ? style_s    : mode_split_q;

	// Style is sampled only while the reset pin is active, so a glitch
	// on the select pin cannot swap bus styles mid-operation
	always_ff @(posedge clk) begin
		mode_split_q <= mode_next_w;
	end

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	wire        cs_s     = ~bus_s.cs_n;
	// Combined style: write pin carries read/write, read pin unused
	wire        rd_act_w = cs_s & (mode_split_q ? ~bus_s.rd_n
	                                            : bus_s.wr_n);
	wire        wr_act_w = cs_s & ~bus_s.wr_n;
	logic       rd_act_q;
	logic       wr_act_q;
	wire        rd_go    = rd_act_w & ~rd_act_q;
	wire        wr_go    = wr_act_w & ~wr_act_q;
	wire [1:0]  ch_w     = bus_s.addr[4:3];
	wire [2:0]  off_w    = bus_s.addr[2:0];
	wire [4:0]  idx_w    = bus_s.addr;

	// ------------------------------------------------------------
	// Register storage and call flags
	// ------------------------------------------------------------
	logic [7:0]          regs_q [NREG];
	logic [CHANNELS-1:0] call_prev_q;
	logic [CHANNELS-1:0] call_flag_q;
	wire  [CHANNELS-1:0] call_rise   = call_n_s & ~call_prev_q;
	wire  [CHANNELS-1:0] call_clr;
	wire  [CHANNELS-1:0] cond_w;
	wire  [CHANNELS-1:0] int_out_w;
	wire  [CHANNELS-1:0] rts_w;

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_ch
			localparam int B = g * REGS_PER_CH;
			wire [7:0] int_en    = regs_q[B + 32'(OFF_INT_EN)];
			wire [7:0] modem_ctl = regs_q[B + 32'(OFF_MODEM_CTL)];
			wire [7:0] feat      = regs_q[B + 32'(OFF_STAT_FEAT)];
			// Reading modem status clears the flag
			assign call_clr[g]  = rd_go & (ch_w == 2'(g))
			                    & (off_w == OFF_MODEM_ST);
			// Enabled interrupt condition of this channel
			assign cond_w[g]    = call_flag_q[g] & int_en[INT_EN_MODEM_BIT];
			assign int_out_w[g] = cond_w[g]
			                    & modem_ctl[MODEM_CTL_INT_OE_BIT];
			// Auto flow: hold RTS off while receive side has no room
			assign rts_w[g]     = modem_ctl[MODEM_CTL_RTS_BIT]
			                    & (~feat[FEAT_AUTO_RTS_BIT]
			                       | rx_room[g]);
		end
	endgenerate

	// Writes land in the addressed register; set beats clear on flags
	always_ff @(posedge clk) begin
		if (rst_any) begin
			for (int i = 0; i < NREG; i++)
				regs_q[i] <= REG_RESET;
			call_prev_q <= {CHANNELS{1'b1}};
			call_flag_q <= '0;
		end else begin
			if (wr_go)
				regs_q[idx_w] <= bus_s.data;
			call_prev_q <= call_n_s;
			call_flag_q <= (call_flag_q & ~call_clr) | call_rise;
		end
	end

	// ------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------
	wire [7:0] isr_w = {7'h00, ~cond_w[ch_w]};
	wire       call_lvl_w = ~call_n_s[ch_w];
	wire       call_flg_w = call_flag_q[ch_w];
	// Widen before shifting so no inverted upper bits leak in
	wire [7:0] msr_w = (8'(call_lvl_w) << MSR_CALL_LEVEL)
	                 | (8'(call_flg_w) << MSR_CALL_FLAG);
	wire [7:0] rd_data_w = (off_w == OFF_STAT_FEAT) ? isr_w :
	                       (off_w == OFF_MODEM_ST)  ? msr_w :
	                       regs_q[idx_w];

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Data captured at strobe start and kept until the next read; drive released once strobe or select ends
	always_ff @(posedge clk) begin
		if (rst_any) begin
			rd_act_q  <= 1'b0;
			wr_act_q  <= 1'b0;
			data_out  <= DATA_RESET;
			data_oe_n <= 1'b1;
		end else begin
			rd_act_q  <= rd_act_w;
			wr_act_q  <= wr_act_w;
			if (rd_go)
				data_out <= rd_data_w;
			data_oe_n <= ~rd_act_w;
		end
	end

	// Interrupt, modem and serial pins; reset forces idle levels
	always_ff @(posedge clk) begin
		if (rst_any) begin
			irq_pin           <= ~mode_next_w;
			chan_int_bcd      <= '0;
			request_to_send_n <= {CHANNELS{1'b1}};
			tx_pin            <= {CHANNELS{1'b1}};
			rx_serial         <= {CHANNELS{1'b1}};
		end else begin
			irq_pin           <= mode_split_q ? int_out_w[0]
			                                  : ~(|cond_w);
			chan_int_bcd      <= mode_split_q ? int_out_w[CHANNELS-1:1]
			                                  : '0;
			request_to_send_n <= ~rts_w;
			tx_pin            <= tx_serial;
			rx_serial         <= rx_s;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst_any);

	sequence s_read_start;
		rd_go && mode_split_q;
	endsequence
	sequence s_bus_driven;
		!data_oe_n ##0 (data_out == $past(rd_data_w));
	endsequence

	property p_read_drive;
		s_read_start |=> s_bus_driven;
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("read strobe did not drive selected register");

	property p_write_store;
		wr_go && mode_split_q |=> regs_q[$past(idx_w)] == $past(bus_s.data);
	endproperty
	a_write_store: assert property (p_write_store)
		else $error("write strobe did not store bus data");

	property p_rd_ignored;
		!mode_split_q && cs_s && !bus_s.wr_n |=> data_oe_n;
	endproperty
	a_rd_ignored: assert property (p_rd_ignored)
		else $error("read strobe acted in combined style");

	property p_irq_shared;
		!mode_split_q && (|cond_w) |=> !irq_pin;
	endproperty
	a_irq_shared: assert property (p_irq_shared)
		else $error("shared request not low with pending channel");

	property p_int_a;
		mode_split_q |=> irq_pin == $past(int_out_w[0]);
	endproperty
	a_int_a: assert property (p_int_a)
		else $error("request pin not following channel A");

	property p_reset_idle;
		disable iff (reset)
		pin_rst_w |=> (&request_to_send_n) && (&tx_pin) && (&rx_serial);
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("serial or RTS pins not idle in reset");

	property p_call_flag;
		call_rise[1] |=> call_flag_q[1];
	endproperty
	a_call_flag: assert property (p_call_flag)
		else $error("incoming call edge did not set flag");

	property p_rts;
		rts_w[2] |=> !request_to_send_n[2];
	endproperty
	a_rts: assert property (p_rts)
		else $error("RTS not asserted by control bit");

	property p_int_gate;
		mode_split_q && !regs_q[12][MODEM_CTL_INT_OE_BIT] |=> !chan_int_bcd[1];
	endproperty
	a_int_gate: assert property (p_int_gate)
		else $error("channel interrupt active without output enable");

	property p_cs_release;
		!cs_s |=> data_oe_n;
	endproperty
	a_cs_release: assert property (p_cs_release)
		else $error("data bus driven without chip select");

endmodule // qhb_host_pins

// File: hw/qhb_pkg.sv
// Package for the quad UART host bus pin block: offsets, bit positions,
// reset values and the carrier struct of the host bus inputs.
// Assumes one 40 MHz clock domain; host pins are asynchronous to it.
package qhb_pkg;

	// ------------------------------------------------------------
	// Clock and geometry
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 40;
	localparam int CHANNELS      = 4;
	localparam int REGS_PER_CH   = 8;
	localparam int ADDR_W        = 5;
	localparam int DATA_W        = 8;
	localparam int SYNC_STAGES   = 2;

	// ------------------------------------------------------------
	// Register offsets within one channel (low three address bits)
	// ------------------------------------------------------------
	localparam logic [2:0] OFF_DATA      = 3'h0;
	localparam logic [2:0] OFF_INT_EN    = 3'h1;
	localparam logic [2:0] OFF_STAT_FEAT = 3'h2;
	localparam logic [2:0] OFF_LINE_CTL  = 3'h3;
	localparam logic [2:0] OFF_MODEM_CTL = 3'h4;
	localparam logic [2:0] OFF_LINE_STAT = 3'h5;
	localparam logic [2:0] OFF_MODEM_ST  = 3'h6;
	localparam logic [2:0] OFF_SCRATCH   = 3'h7;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODEM_CTL_RTS_BIT    = 1;
	localparam int MODEM_CTL_INT_OE_BIT = 3;
	localparam int FEAT_AUTO_RTS_BIT    = 6;
	localparam int INT_EN_MODEM_BIT     = 3;
	localparam int MSR_CALL_FLAG   = 2;
	localparam int MSR_CALL_LEVEL  = 6;
	localparam int ISR_NONE_BIT    = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam logic [7:0] DATA_RESET   = 8'h00;
	localparam logic       MODE_RESET   = 1'b1;

	// Host bus inputs as they arrive on the pins
	typedef struct packed {
		logic                cs_n;
		logic                rd_n;
		logic                wr_n;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} qhb_bus_t;

	// Select and both strobes high, address and data low
	localparam logic [$bits(qhb_bus_t)-1:0] BUS_IDLE = 16'hE000;

endpackage

// File: verif/qhb_host_model.sv
// Host bus master and modem model facing the host pin block.
// Assumes the bench calls its tasks; pins change just after falling clk.
`timescale 1ns/1ps
module qhb_host_model (
	input  wire logic              clk,
	input  wire logic [7:0]        data_out,
	input  wire logic              data_oe_n,
	output qhb_pkg::qhb_bus_t      bus,
	output logic      [3:0]        call_n
);
	import qhb_pkg::*;

	// Idle pins at time zero; call lines idle high
	initial begin
		bus = qhb_bus_t'(BUS_IDLE);
		call_n = 4'hF;
	end

	// One register cycle, strobe held 6 clocks; answer taken before release
	task automatic access(input logic comb, input logic rd, input logic cs,
		input logic [4:0] a, input logic [7:0] wd,
		output logic [7:0] rdat, output logic oe_n);
		@(negedge clk);
		bus.cs_n = cs;
		bus.addr = a; // Channel in upper bits
		bus.data = rd ? ~bus.data : wd; // Host drives data on writes
		bus.wr_n = rd; // Split write strobe, or combined read/write
		bus.rd_n = comb ? 1'b0 : ~rd; // Wiggled in combined style
		repeat (6) @(negedge clk);
		rdat = data_out;
		oe_n = data_oe_n;
		bus.cs_n = 1'b1;
		bus.rd_n = 1'b1;
		bus.wr_n = 1'b1;
		bus.data = ~bus.data; // Released bus shows no stale value
		repeat (6) @(negedge clk);
	endtask

	// Incoming call: low for 5 clocks, then rising edge
	task automatic ring(input int ch);
		@(negedge clk);
		call_n[ch] = 1'b0;
		repeat (5) @(negedge clk);
		call_n[ch] = 1'b1;
		repeat (6) @(negedge clk);
	endtask
endmodule // qhb_host_model

// File: verif/tb_quad_uart_host_bus_pins.sv
// Self-checking bench for the host pin block, split and combined styles.
// Assumes a 40 MHz clock; the host model sits on the bus pins.
`timescale 1ns/1ps
module tb_quad_uart_host_bus_pins;
	import qhb_pkg::*;
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic              bus_style_pin = 1'b1;
	logic              reset_pin = 1'b0;
	logic [3:0]        rx_room = 4'hF;
	logic [3:0]        tx_serial = 4'h0;
	logic [3:0]        rx_pin = 4'h0;
	qhb_bus_t          host_bus;
	logic [3:0]        call_n, rts_n, tx_pin, rx_serial;
	logic [7:0]        data_out, rv;
	logic              data_oe_n, irq_pin, ov, comb = 1'b0;
	logic [3:1]        chan_int_bcd;
	int                n_errors = 0, tests_run = 0, cyc = 0;

	qhb_host_model u_host (.clk(clk), .data_out(data_out),
		.data_oe_n(data_oe_n), .bus(host_bus), .call_n(call_n));
	qhb_host_pins u_dut (.clk(clk), .reset(reset),
		.bus_style_pin(bus_style_pin), .reset_pin(reset_pin),
		.host_bus(host_bus), .incoming_call_input_n(call_n),
		.rx_room(rx_room), .tx_serial(tx_serial), .rx_pin(rx_pin),
		.data_out(data_out), .data_oe_n(data_oe_n), .irq_pin(irq_pin),
		.chan_int_bcd(chan_int_bcd), .request_to_send_n(rts_n),
		.tx_pin(tx_pin), .rx_serial(rx_serial));

	// ------------------------------------------------------------
	// Clock, hang guard and helpers
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;

	// Whole run needs about 420 clocks; 4000 leaves margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_errors++;
			$display("FAIL %0t run hung", $time);
			final_report();
		end
	end

	task automatic chk(input logic [7:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		u_host.access(comb, 1'b0, 1'b0, a, d, rv, ov);
	endtask
	task automatic rd(input logic [4:0] a);
		u_host.access(comb, 1'b1, 1'b0, a, 8'h00, rv, ov);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_rw();
		for (int c = 0; c < 4; c++) wr({2'(c), OFF_SCRATCH}, 8'hA5 + 8'(c));
		for (int c = 0; c < 4; c++) begin
			rd({2'(c), OFF_SCRATCH});
			chk(rv, 8'hA5 + 8'(c), "scratch");
			chk({7'h0, ov}, 8'h00, "drive");
		end
		u_host.access(comb, 1'b0, 1'b1, {2'd1, OFF_SCRATCH}, 8'h3C, rv, ov);
		u_host.access(comb, 1'b1, 1'b1, {2'd1, OFF_SCRATCH}, 8'h00, rv, ov);
		chk({7'h0, ov}, 8'h01, "no select");
		rd({2'd1, OFF_SCRATCH});
		chk(rv, 8'hA6, "unselected write");
		chk({7'h0, data_oe_n}, 8'h01, "idle bus");
		$display("test rw done");
	endtask

	task automatic t_rts();
		wr({2'd2, OFF_MODEM_CTL}, 8'h02);
		chk({4'h0, rts_n}, 8'h0B, "rts set");
		rx_room = 4'h0;
		tick(2);
		chk({4'h0, rts_n}, 8'h0B, "no auto");
		wr({2'd2, OFF_STAT_FEAT}, 8'h40);
		chk({4'h0, rts_n}, 8'h0F, "auto full");
		rx_room = 4'hF;
		tick(2);
		chk({4'h0, rts_n}, 8'h0B, "auto room");
		$display("test rts done");
	endtask

	task automatic t_pin_reset();
		reset_pin = 1'b1;
		tick(8);
		chk({4'h0, rts_n}, 8'h0F, "rts");
		chk({tx_pin, rx_serial}, 8'hFF, "serial");
		chk({4'h0, data_oe_n, irq_pin, chan_int_bcd[2:1]}, 8'h08, "outs");
		reset_pin = 1'b0;
		tx_serial = 4'h5;
		rx_pin = 4'hA;
		tick(5);
		chk({tx_pin, rx_serial}, 8'h5A, "serial run");
		rd({2'd1, OFF_SCRATCH});
		chk(rv, REG_RESET, "reg reset");
		$display("test pin reset done");
	endtask

	task automatic t_int_split();
		wr({2'd0, OFF_INT_EN}, 8'h08);
		wr({2'd0, OFF_MODEM_CTL}, 8'h08);
		wr({2'd1, OFF_INT_EN}, 8'h08);
		u_host.ring(0);
		u_host.ring(1);
		chk({4'h0, irq_pin, chan_int_bcd}, 8'h08, "split ints");
		wr({2'd1, OFF_MODEM_CTL}, 8'h08);
		chk({5'h0, chan_int_bcd}, 8'h01, "ch b out");
		rd({2'd0, OFF_MODEM_ST});
		chk({7'h0, rv[2]}, 8'h01, "call flag");
		chk({7'h0, irq_pin}, 8'h00, "cleared");
		$display("test split int done");
	endtask

	task automatic t_comb();
		reset_pin = 1'b1;
		bus_style_pin = 1'b0;
		reset = 1'b1;
		tick(8);
		reset = 1'b0;
		tick(8);
		comb = 1'b1;
		chk({7'h0, irq_pin}, 8'h01, "req idle");
		wr({2'd3, OFF_SCRATCH}, 8'h96);
		rd({2'd3, OFF_SCRATCH});
		chk(rv, 8'h96, "rw line");
		wr({2'd3, OFF_INT_EN}, 8'h08);
		u_host.ring(3);
		chk({4'h0, irq_pin, chan_int_bcd}, 8'h00, "shared req");
		rd({2'd3, OFF_STAT_FEAT});
		chk({7'h0, rv[0]}, 8'h00, "ch d pending");
		rd({2'd2, OFF_STAT_FEAT});
		chk({7'h0, rv[0]}, 8'h01, "ch c quiet");
		wr({2'd3, OFF_MODEM_CTL}, 8'h02);
		chk({4'h0, rts_n}, 8'h07, "rts d");
		reset_pin = 1'b0;
		tick(8);
		chk({4'h0, rts_n}, 8'h0F, "low reset");
		reset_pin = 1'b1;
		tick(5);
		$display("test combined done");
	endtask

	// Main sequence: system reset 8 clocks, then scenarios
	initial begin
		tick(8);
		reset = 1'b0;
		tick(4);
		t_rw();
		t_rts();
		t_pin_reset();
		t_int_split();
		t_comb();
		final_report();
	end
endmodule // tb_quad_uart_host_bus_pins
